// >>> include/dci_defines.svh
// constants for the dual-channel two-wire target: offsets, resets, address, timing
`ifndef DCI_DEFINES_SVH
`define DCI_DEFINES_SVH

// ----------------------------------------------------------------
// register pointers and reset values
// ----------------------------------------------------------------
`define DCI_REG_SIGNATURE  8'h00
`define DCI_REG_SPARE      8'h01
`define DCI_SPARE_RST      8'h00
`define DCI_SIG_CODE_MSB   7
`define DCI_SIG_CODE_LSB   4
`define DCI_SIG_REV_MSB    3
`define DCI_SIG_REV_LSB    0

// ----------------------------------------------------------------
// bus address layout and protocol figures
// ----------------------------------------------------------------
`define DCI_ADDR_FIXED     4'b0111
`define DCI_GEN_CALL       8'h00
`define DCI_RW_READ        1'b1
`define DCI_BYTE_BITS      4'h8

// ----------------------------------------------------------------
// timing: fastest serial clock against the core clock
// ----------------------------------------------------------------
`define DCI_CLK_PERIOD_NS  5
`define DCI_SCL_MAX_KHZ    1000
`define DCI_SCL_PERIOD_NS  (1000000 / `DCI_SCL_MAX_KHZ)
`define DCI_SCL_PERIOD_CYC ((`DCI_SCL_PERIOD_NS + `DCI_CLK_PERIOD_NS - 1) / `DCI_CLK_PERIOD_NS)
`define DCI_MIN_SCL_CYC    16

`endif

// >>> include/dci_pkg.sv
// types shared by the two-wire target design
package dci_pkg;

    // protocol state of the target
    typedef enum logic [2:0] {
        DCI_IDLE,
        DCI_RX,
        DCI_ACK,
        DCI_TX,
        DCI_TXACK,
        DCI_IGNORE
    } dci_state_t;

    // meaning of the byte being received
    typedef enum logic [1:0] {
        DCI_K_ADDR,
        DCI_K_PTR,
        DCI_K_DATA
    } dci_kind_t;

    // synchronised bus levels
    typedef struct packed {
        logic scl;
        logic sda;
    } dci_bus_t;

    // register write carried to a channel
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } dci_wr_t;

endpackage : dci_pkg

// >>> logic/dci_sync2.sv
// two-flop synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
module dci_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // async level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : dci_sync2

// >>> logic/dci_chan_regs.sv
// one channel's register set: signature byte and spare byte
`timescale 1ns/1ps
`include "dci_defines.svh"
module dci_chan_regs #(
    parameter logic [3:0] DEV_CODE = 4'h5,   // arbitrary value
    parameter logic [3:0] REV_CODE = 4'h1    // arbitrary value
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // write strobe with pointer and data
    input  wire logic          wr_en,
    input  wire dci_pkg::dci_wr_t wr,
    // read port
    input  wire logic [7:0]    rd_ptr,
    output logic      [7:0]    rd_data,
    // active copy of the spare byte
    output logic      [7:0]    spare
);
    import dci_pkg::*;

    logic [7:0] spare_q;
    logic [7:0] sig;
    logic       hit_spare;

    // signature: code in upper nibble, revision in lower
    assign sig = {DEV_CODE, REV_CODE};                  // [R17]
    assign hit_spare = wr_en && (wr.ptr == `DCI_REG_SPARE);
    assign spare = spare_q;

    // read mux: unmapped pointers read zero
    assign rd_data = (rd_ptr == `DCI_REG_SIGNATURE) ? sig :
                     (rd_ptr == `DCI_REG_SPARE)     ? spare_q : 8'h00;

    // spare byte: only writable location, signature is read-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spare_q <= `DCI_SPARE_RST;                  // [R17]
        end else if (hit_spare) begin
            spare_q <= wr.data;
        end
    end
endmodule : dci_chan_regs

// >>> logic/dci_i2c_target.sv
// two-wire serial target answering at one address per output channel
`timescale 1ns/1ps
`include "dci_defines.svh"

// Contract
// R1: SDA fall with SCL high starts
// R2: SDA rise with SCL high stops
// R3: repeated start: next byte is address
// R4: stop aborts, unless same high as start
// R5: never hold the clock low
// R6: general call byte is not acknowledged
// R7: first byte: address then direction bit
// R8: address 0111, preset bits, select pin
// R9: each channel has its own address
// R10: ack pulls data low through ninth clock
// R11: master writes address, pointer, data, stop
// R12: master reads via pointer, restart, nack
// R13: data commits on next data rising edge
// R14: pointer-data pairs repeat until stop
// R15: last data commits on stop edge
// R16: identical independent register set per channel
// R17: pointer 0 signature, 1 spare byte
// R18: master retries on missing acknowledge
// R19: data changes only while clock low
// R20: clock input only, data open drain
// R21: serial clock up to 1 MHz
// R22: release data after ack and read byte
module dci_i2c_target #(
    parameter logic [1:0] CH0_PRESET = 2'b00,
    parameter logic [1:0] CH1_PRESET = 2'b01,
    parameter logic [3:0] CH0_DEV    = 4'h5,   // arbitrary value
    parameter logic [3:0] CH1_DEV    = 4'h6,   // arbitrary value
    parameter logic [3:0] REV        = 4'h1    // arbitrary value
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // serial clock, input only
    input  wire logic       scl_in,
    // serial data, open drain
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // address select strap
    input  wire logic       addr_sel,
    // channel register contents and status
    output logic [1:0][7:0] spare_byte,
    output logic            bus_busy
);
    import dci_pkg::*;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (CH0_PRESET == CH1_PRESET) begin : g_bad_preset
        $error("channel address presets must differ");
    end
    if (`DCI_SCL_PERIOD_CYC < `DCI_MIN_SCL_CYC) begin : g_bad_rate      // [R21]
        $error("core clock too slow for the serial clock rate");
    end

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_m_q;
    logic rst_n;

    // async assert, two-flop release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    dci_bus_t bus_s;
    dci_bus_t bus_q;
    logic     addr_s;

    dci_sync2 #(.W(2)) u_bus_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({scl_in, sda_in}),
        .q     (bus_s)
    );

    dci_sync2 #(.W(1)) u_strap_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (addr_sel),
        .q     (addr_s)
    );

    // previous synchronised levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= '1;
        end else begin
            bus_q <= bus_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic start_ev;
    logic stop_ev;

    // clock edges and bus conditions
    assign scl_rise = bus_s.scl && !bus_q.scl;
    assign scl_fall = !bus_s.scl && bus_q.scl;
    assign sda_rise = bus_s.sda && !bus_q.sda;
    assign start_ev = bus_s.scl && bus_q.scl && !bus_s.sda && bus_q.sda;   // [R1] [R19]
    assign stop_ev  = bus_s.scl && bus_q.scl && bus_s.sda && !bus_q.sda;   // [R2] [R19]

    // ----------------------------------------------------------------
    // address strap, caught once its synchroniser has filled
    // ----------------------------------------------------------------
    logic [1:0] strap_cnt_q;
    logic       addr_lsb_q;

    // sync stages leave reset at '1, so wait until the pin level is through
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q <= 2'h0;
            addr_lsb_q  <= 1'b0;
        end else if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            addr_lsb_q  <= addr_s;                      // [R8]
        end
    end

    // ----------------------------------------------------------------
    // protocol state
    // ----------------------------------------------------------------
    dci_state_t state_q;
    dci_kind_t  kind_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic       chan_q;
    logic       rd_q;
    logic       drive_q;
    logic       start_hi_q;
    logic       nack_q;

    // pending write, committed on the next data rising edge
    logic       pend_q;
    logic       pend_ch_q;
    dci_wr_t    pend_wr_q;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [6:0] ch0_addr;
    logic [6:0] ch1_addr;
    logic       hit0;
    logic       hit1;
    logic       gen_call;
    logic       addr_ok;
    logic       byte_done;

    assign ch0_addr  = {`DCI_ADDR_FIXED, CH0_PRESET, addr_lsb_q};        // [R8] [R9]
    assign ch1_addr  = {`DCI_ADDR_FIXED, CH1_PRESET, addr_lsb_q};        // [R8] [R9]
    assign hit0      = (rx_q[7:1] == ch0_addr);                          // [R7]
    assign hit1      = (rx_q[7:1] == ch1_addr);                          // [R7]
    assign gen_call  = (rx_q == `DCI_GEN_CALL);                          // [R6]
    assign addr_ok   = (hit0 || hit1) && !gen_call;                      // [R6]
    assign byte_done = scl_fall && (cnt_q == `DCI_BYTE_BITS);

    // ----------------------------------------------------------------
    // channel register sets
    // ----------------------------------------------------------------
    logic [1:0][7:0] rd_data;
    logic [1:0]      wr_en;
    logic [7:0]      rd_byte;
    logic            commit;

    // a pending write lands on any data rise, stop edge included
    assign commit = pend_q && sda_rise;                                  // [R13] [R15]
    assign wr_en  = {commit && pend_ch_q, commit && !pend_ch_q};
    assign rd_byte = rd_data[chan_q];

    // identical, independent set per channel
    for (genvar i = 0; i < 2; i++) begin : g_chan                       // [R16]
        dci_chan_regs #(
            .DEV_CODE (i == 0 ? CH0_DEV : CH1_DEV),
            .REV_CODE (REV)
        ) u_regs (
            .clk     (clk),
            .rst_n   (rst_n),
            .wr_en   (wr_en[i]),
            .wr      (pend_wr_q),
            .rd_ptr  (ptr_q),
            .rd_data (rd_data[i]),
            .spare   (spare_byte[i])
        );
    end

    // ----------------------------------------------------------------
    // pending write tracking
    // ----------------------------------------------------------------
    logic take_data;

    assign take_data = (state_q == DCI_RX) && byte_done && (kind_q == DCI_K_DATA);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q    <= 1'b0;
            pend_ch_q <= 1'b0;
            pend_wr_q <= '0;
        end else if (take_data) begin
            pend_q    <= 1'b1;                          // new data wins over commit
            pend_ch_q <= chan_q;
            pend_wr_q <= '{ptr: ptr_q, data: rx_q};
        end else if (commit) begin
            pend_q    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // start seen in the current clock-high pulse
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_hi_q <= 1'b0;
        end else if (start_ev) begin
            start_hi_q <= 1'b1;
        end else if (scl_fall) begin
            start_hi_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DCI_IDLE;
            kind_q  <= DCI_K_ADDR;
            cnt_q   <= 4'h0;
            rx_q    <= 8'h00;
            tx_q    <= 8'h00;
            ptr_q   <= 8'h00;
            chan_q  <= 1'b0;
            rd_q    <= 1'b0;
            drive_q <= 1'b0;
            nack_q  <= 1'b0;
        end else if (start_ev) begin
            state_q <= DCI_RX;                          // [R1] [R3]
            kind_q  <= DCI_K_ADDR;                      // [R3]
            cnt_q   <= 4'h0;
            drive_q <= 1'b0;
        end else if (stop_ev && !start_hi_q) begin
            state_q <= DCI_IDLE;                        // [R2] [R4]
            drive_q <= 1'b0;
        end else begin
            case (state_q)
                DCI_RX: begin
                    if (scl_rise) begin
                        rx_q  <= {rx_q[6:0], bus_s.sda};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        cnt_q <= 4'h0;
                        case (kind_q)
                            DCI_K_ADDR: begin
                                if (addr_ok) begin
                                    chan_q  <= hit1;    // [R9]
                                    rd_q    <= (rx_q[0] == `DCI_RW_READ);   // [R7]
                                    kind_q  <= DCI_K_PTR;
                                    state_q <= DCI_ACK;
                                    drive_q <= 1'b1;    // [R10]
                                end else begin
                                    state_q <= DCI_IGNORE;   // [R6]
                                end
                            end
                            DCI_K_PTR: begin
                                ptr_q   <= rx_q;        // [R17]
                                kind_q  <= DCI_K_DATA;
                                state_q <= DCI_ACK;
                                drive_q <= 1'b1;        // [R10]
                            end
                            default: begin
                                kind_q  <= DCI_K_PTR;   // [R14]
                                state_q <= DCI_ACK;
                                drive_q <= 1'b1;        // [R10]
                            end
                        endcase
                    end
                end
                DCI_ACK: begin
                    // hold low through the ninth high phase; at its fall free the line, or drive bit 7 for a read
                    if (scl_fall) begin
                        if (rd_q) begin
                            tx_q    <= rd_byte;
                            drive_q <= !rd_byte[7];
                            state_q <= DCI_TX;
                        end else begin
                            drive_q <= 1'b0;            // [R22]
                            state_q <= DCI_RX;
                        end
                    end
                end
                DCI_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == `DCI_BYTE_BITS) begin
                            drive_q <= 1'b0;            // [R22]
                            cnt_q   <= 4'h0;
                            state_q <= DCI_TXACK;
                        end else begin
                            tx_q    <= {tx_q[6:0], 1'b0};
                            drive_q <= !tx_q[6];        // [R19]
                        end
                    end
                end
                DCI_TXACK: begin
                    if (scl_rise) begin
                        nack_q <= bus_s.sda;
                        if (!bus_s.sda) begin
                            ptr_q <= ptr_q + 8'h01;     // sequential read
                        end
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            state_q <= DCI_IGNORE;      // master ends read
                        end else begin
                            tx_q    <= rd_byte;
                            drive_q <= !rd_byte[7];
                            state_q <= DCI_TX;
                        end
                    end
                end
                DCI_IGNORE: begin
                    drive_q <= 1'b0;
                end
                default: begin
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive: data pulled low only, clock never driven
    // ----------------------------------------------------------------
    assign sda_out  = 1'b0;                             // [R20]
    assign sda_oe_n = !drive_q;                         // [R20] [R5]
    assign bus_busy = (state_q != DCI_IDLE);

endmodule : dci_i2c_target

// >>> testbench/dci_i2c_target_assertions.sv
// concurrent checks on the ports of the two-wire target
`timescale 1ns/1ps
module dci_i2c_target_assertions (
    // clock and reset
    input wire logic            clk,
    input wire logic            resetn,
    // serial pins
    input wire logic            scl_in,
    input wire logic            sda_in,
    input wire logic            sda_out,
    input wire logic            sda_oe_n,
    input wire logic            addr_sel,
    // register contents and status
    input wire logic [1:0][7:0] spare_byte,
    input wire logic            bus_busy
);
    // ----------------------------------------------------------------
    // pin history: data rise age and start seen in this clock high
    // ----------------------------------------------------------------
    logic       sda_q;
    logic       start_hi_q;
    logic       start_hi_d;
    logic [3:0] since_q;
    logic [3:0] since_d;

    // age saturates so an old rise never looks fresh
    assign start_hi_d = scl_in && (start_hi_q || (sda_q && !sda_in));
    assign since_d    = (!sda_q && sda_in) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};

    // history registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_q      <= 1'b1;
            start_hi_q <= 1'b0;
            since_q    <= 4'hf;
        end else begin
            sda_q      <= sda_in;
            start_hi_q <= start_hi_d;
            since_q    <= since_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_start_busy: assert property (sda_q && !sda_in && scl_in |-> ##[1:8] bus_busy)
        else $error("bus not busy after start");
    a_stop_idle: assert property (!sda_q && sda_in && scl_in && !start_hi_q |-> ##[1:8] !bus_busy)
        else $error("bus still busy after stop");
    a_stop_same_high: assert property (!sda_q && sda_in && scl_in && start_hi_q |-> ##8 bus_busy)
        else $error("stop in the start pulse was honoured");
    a_drive_low_only: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_oe_clock_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_idle_release: assert property (!bus_busy |-> sda_oe_n)
        else $error("data pulled low while idle");
    a_commit_edge: assert property ($changed(spare_byte) |-> since_q < 4'hc)
        else $error("register changed without a data rise");
    a_reset_values: assert property ($rose(resetn) |-> spare_byte == '0 && sda_oe_n && !bus_busy)
        else $error("wrong values at reset release");
endmodule : dci_i2c_target_assertions

// >>> testbench/dci_i2c_master.sv
// behavioural two-wire bus master, 48 ns per bit
`timescale 1ns/1ps
module dci_i2c_master (
    // serial clock, the master owns it
    output logic      scl,
    // data drive, 1 lets the pull-up win
    output logic      sda_drv,
    // data level on the wire
    input  wire logic sda
);
    // bus idles high, clock stands still between frames
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // ----------------------------------------------------------------
    // bus conditions and bit cycles
    // ----------------------------------------------------------------
    // start or repeated start
    task automatic start_c();
        #12 sda_drv = 1'b1;
        #16 scl = 1'b1;
        #12 sda_drv = 1'b0;
        #12 scl = 1'b0;
    endtask : start_c

    // stop frees the bus; data low right after the fall, so a
    // pending write sees no rise before the stop edge
    task automatic stop_c();
        #2 sda_drv = 1'b0;
        #26 scl = 1'b1;
        #12 sda_drv = 1'b1;
        #12;
    endtask : stop_c

    // start and stop within one clock high, then clocking resumes
    task automatic blip();
        #12 sda_drv = 1'b0;
        #12 sda_drv = 1'b1;
        #12 scl = 1'b0;
    endtask : blip

    // one bit: data set mid-low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        #12 sda_drv = b;
        #16 scl = 1'b1;
        #10 r = sda;
        #10 scl = 1'b0;
    endtask : bit_x
endmodule : dci_i2c_master

// >>> testbench/dci_i2c_target_bench.sv
// self-checking bench for the dual-channel two-wire target
`timescale 1ns/1ps
module dci_i2c_target_bench;
    // ----------------------------------------------------------------
    // clock, wires and reference state
    // ----------------------------------------------------------------
    logic            clk      = 1'b0;
    logic            resetn   = 1'b0;
    logic            addr_sel = 1'b0;
    logic            scl;
    logic            sda_m;
    wire logic       sda;
    logic            sda_out;
    logic            sda_oe_n;
    logic            bus_busy;
    logic [1:0][7:0] spare_byte;
    logic            r_bit;
    int              errors   = 0;
    int              n_tests  = 0;
    int              cycles   = 0;
    int              strap    = 0;
    int              ref_spare [2];
    int              q [$];

    always #2.5 clk = ~clk;
    // open drain: whoever pulls low wins
    assign sda = sda_m & (sda_oe_n | sda_out);

    dci_i2c_target u_dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
        .spare_byte(spare_byte), .bus_busy(bus_busy));
    dci_i2c_master u_mst (.scl(scl), .sda_drv(sda_m), .sda(sda));

    // reference: address byte of a channel
    function automatic int addr_of(input int ch, input int rd);
        return ((ch ? 'h3a : 'h38) + strap) * 2 + rd;
    endfunction : addr_of

    // reference: channel an address byte selects, -1 for none
    function automatic int chan_of(input int a);
        for (int ch = 0; ch < 2; ch++) if (a == addr_of(ch, 0)) return ch;
        return -1;
    endfunction : chan_of

    // reference: byte read at a pointer
    function automatic int exp_rd(input int ch, input int ptr);
        if (ptr == 0) return ch ? 'h61 : 'h51;
        return (ptr == 1) ? ref_spare[ch] : 0;
    endfunction : exp_rd

    // ----------------------------------------------------------------
    // compare, transfer and closing tasks
    // ----------------------------------------------------------------
    task automatic chk_bit(input logic got, input int exp);
        n_tests++;
        if (got !== exp[0]) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp[0]);
        end
    endtask : chk_bit

    task automatic chk_byte(input logic [7:0] got, input int exp);
        n_tests++;
        if (got !== exp[7:0]) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp[7:0]);
        end
    endtask : chk_byte

    task automatic end_of_test();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // byte out, then the ninth bit must carry the expected answer
    task automatic send(input int b, input int nack);
        logic r;
        for (int i = 7; i >= 0; i--) u_mst.bit_x(b[i], r);
        u_mst.bit_x(1'b1, r);
        chk_bit(r, nack);
    endtask : send

    // byte in, then the master's answer
    task automatic recv(input int exp, input logic last);
        logic [7:0] d;
        logic       r;
        for (int i = 7; i >= 0; i--) u_mst.bit_x(1'b1, d[i]);
        u_mst.bit_x(last, r);
        chk_byte(d, exp);
    endtask : recv

    task automatic do_reset(input int s);
        @(negedge clk);
        resetn   = 1'b0;
        addr_sel = s[0];
        strap    = s;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        ref_spare = '{0, 0};
        #0.3;
        chk_byte(spare_byte[0], 0);
        chk_byte(spare_byte[1], 0);
        chk_bit(bus_busy, 0);
    endtask : do_reset

    // pointer and data pairs; early checks after each data byte
    task automatic wr_pairs(input int ch, input bit early);
        u_mst.start_c();
        send(addr_of(ch, 0), 0);
        for (int i = 0; i < q.size(); i += 2) begin
            send(q[i], 0);
            send(q[i+1], 0);
            if (q[i] == 1) ref_spare[ch] = q[i+1];
            if (early) begin
                #40;
                chk_byte(spare_byte[ch], ref_spare[ch]);
            end
        end
        u_mst.stop_c();
        #60;
        chk_byte(spare_byte[0], ref_spare[0]);
        chk_byte(spare_byte[1], ref_spare[1]);
    endtask : wr_pairs

    task automatic rd_seq(input int ch, input int ptr, input int n);
        u_mst.start_c();
        send(addr_of(ch, 0), 0);
        send(ptr, 0);
        u_mst.start_c();
        send(addr_of(ch, 1), 0);
        for (int k = 0; k < n; k++) recv(exp_rd(ch, ptr + k), k == n - 1);
        u_mst.stop_c();
        #60;
    endtask : rd_seq

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(75304));
        for (int s = 1; s >= 0; s--) begin
            do_reset(s);
            q = '{'h70, 'h72, 'h74, 'h76, 'h78, 'h7a, 'h00};
            q.push_back($urandom_range(127) * 2);
            foreach (q[i]) begin
                u_mst.start_c();
                send(q[i], chan_of(q[i]) < 0);
                u_mst.stop_c();
            end
        end
        u_mst.start_c();
        send(0, 1);
        send(addr_of(0, 0), 1);
        u_mst.stop_c();
        u_mst.blip();
        send(addr_of(0, 0), 0);
        u_mst.stop_c();
        q = '{1, $urandom_range(255)};
        wr_pairs(0, 1);
        q = '{1, $urandom_range(255), 0, $urandom_range(255), 5, 'h3c, 1, $urandom_range(255)};
        wr_pairs(1, 0);
        rd_seq(0, 0, 3);
        rd_seq(1, 0, 3);
        u_mst.start_c();
        send(addr_of(0, 0), 0);
        send(1, 0);
        for (int i = 0; i < 4; i++) u_mst.bit_x(1'b0, r_bit);
        u_mst.stop_c();
        #60;
        chk_bit(bus_busy, 0);
        rd_seq(0, 1, 1);
        end_of_test();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            end_of_test();
        end
    end
endmodule : dci_i2c_target_bench

bind dci_i2c_target dci_i2c_target_assertions u_chk (.clk(clk), .resetn(resetn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel), .spare_byte(spare_byte), .bus_busy(bus_busy));
